/* hdl/usmc_cfg.sv */
// Configuration registers, serial register port and measurement sequencer of the sensor.
`timescale 1ns/1ps
`include "usmc_defines.svh"
// Contract
// - Mode bits 7:6 select four operating modes.
// - Bit 4 set enters standby, clear leaves.
// - Ready again four microseconds after standby clears.
// - Bit 3 picks push-pull or open-drain ready.
// - Open-drain ready held low while measuring.
// - Bits 1:0 pick conversion clock rate.
// - Pause register sets gap, eight microsecond steps.
// - Zero pause still waits three conversion clocks.
// - Gated mode ends after counted trigger falls.
// - Edge count one to 255, zero means one.
// - Option clear: index set only by STOP.
// - Reads start at index, increment per byte.
// - Option set: STOP resets index to default.
// - Option set: written index used after repeated START.
// - Option reserved bits reset 0111001, host writes zeros.
// - Gated conversion time set by trigger pin.
module usmc_cfg #(
  parameter logic [6:0] DEV_ADDR = `USMC_DEV_ADDR
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       sw_rst,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  output logic            sda_oe_n,
  input  wire logic       external_trigger_pin,
  input  wire logic       cmd_start,
  input  wire logic       conv_done,
  input  wire logic       in_measure_state,
  output logic            ready_level,
  output logic            ready_oe_n,
  output logic [1:0]      operating_mode,
  output logic            standby,
  output logic            awake,
  output logic            busy,
  output logic [1:0]      clock_rate,
  output logic [7:0]      pause_interval,
  output logic [7:0]      edge_count,
  output logic [7:0]      read_index
);
  localparam logic [3:0] BYTE_BITS = 4'h8;
  logic scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall, trig_fall;
  logic i2c_start, i2c_stop, go, meas_end;
  logic [7:0] rd_byte, dflt_idx, ecnt_inc;
  usmc_pkg::usmc_mode_t op_mode;

  usmc_sync u_scl (.clk_sys(clk_sys), .rst(rst), .pin(scl), .level(scl_lvl), .rise(scl_rise), .fall(scl_fall));
  usmc_sync u_sda (.clk_sys(clk_sys), .rst(rst), .pin(sda), .level(sda_lvl), .rise(sda_rise), .fall(sda_fall));
  usmc_sync u_trg (.clk_sys(clk_sys), .rst(rst), .pin(external_trigger_pin), .level(), .rise(), .fall(trig_fall));

  usmc_tick_if tk ();
  usmc_tick_gen u_tick (.clk_sys(clk_sys), .rst(rst), .tk(tk.gen));

  logic [7:0] mode_ff, pause_ff, edge_ff, opt_ff, idx_ff, pend_ff, wp_ff, sh_ff;
  logic [7:0] nxt_mode, nxt_pause, nxt_edge, nxt_opt, nxt_idx, nxt_pend, nxt_wp, nxt_sh;
  logic [3:0] cnt_ff, nxt_cnt;
  logic       rw_ff, first_ff, pend_vld_ff, ack_ff, oe_n_ff;
  logic       nxt_rw, nxt_first, nxt_pend_vld, nxt_ack, nxt_oe_n;
  usmc_pkg::usmc_i2c_t i2c_ff, nxt_i2c;

  assign i2c_start = scl_lvl & sda_fall;
  assign i2c_stop  = scl_lvl & sda_rise;
  assign dflt_idx  = in_measure_state ? `USMC_IDX_MEAS : `USMC_IDX_CFG;

  always_comb begin
    unique case (idx_ff)
      `USMC_ADDR_MODE:  rd_byte = mode_ff;
      `USMC_ADDR_PAUSE: rd_byte = pause_ff;
      `USMC_ADDR_EDGE:  rd_byte = edge_ff;
      `USMC_ADDR_OPT:   rd_byte = opt_ff;
      default:          rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    nxt_mode     = mode_ff;
    nxt_pause    = pause_ff;
    nxt_edge     = edge_ff;
    nxt_opt      = opt_ff;
    nxt_idx      = idx_ff;
    nxt_pend     = pend_ff;
    nxt_wp       = wp_ff;
    nxt_sh       = sh_ff;
    nxt_cnt      = cnt_ff;
    nxt_rw       = rw_ff;
    nxt_first    = first_ff;
    nxt_pend_vld = pend_vld_ff;
    nxt_ack      = ack_ff;
    nxt_oe_n     = oe_n_ff;
    nxt_i2c      = i2c_ff;
    if (i2c_start) begin
      nxt_i2c  = usmc_pkg::I_ADDR;
      nxt_cnt  = 4'h0;
      nxt_oe_n = 1'b1;
      if (opt_ff[`USMC_OPT_BIT] && pend_vld_ff) begin
        nxt_idx = pend_ff;
      end
    end else if (i2c_stop) begin
      nxt_i2c      = usmc_pkg::I_IDLE;
      nxt_oe_n     = 1'b1;
      nxt_pend_vld = 1'b0;
      if (opt_ff[`USMC_OPT_BIT]) begin
        nxt_idx = dflt_idx;
      end else if (pend_vld_ff) begin
        nxt_idx = pend_ff;
      end
    end else if (scl_rise) begin
      if (i2c_ff == usmc_pkg::I_ADDR || i2c_ff == usmc_pkg::I_WR) begin
        nxt_sh  = {sh_ff[6:0], sda_lvl};
        nxt_cnt = cnt_ff + 4'h1;
      end else if (i2c_ff == usmc_pkg::I_RACK) begin
        nxt_ack = sda_lvl;
      end
    end else if (scl_fall) begin
      unique case (i2c_ff)
        usmc_pkg::I_IDLE: nxt_i2c = usmc_pkg::I_IDLE;
        usmc_pkg::I_ADDR: begin
          if (cnt_ff == BYTE_BITS) begin
            if (sh_ff[7:1] == DEV_ADDR) begin
              nxt_i2c  = usmc_pkg::I_AACK;
              nxt_oe_n = 1'b0;
              nxt_rw   = sh_ff[0];
            end else begin
              nxt_i2c = usmc_pkg::I_IDLE;
            end
          end
        end
        usmc_pkg::I_AACK: begin
          nxt_cnt = 4'h0;
          if (rw_ff) begin
            nxt_i2c  = usmc_pkg::I_RD;
            nxt_sh   = rd_byte;
            nxt_oe_n = rd_byte[7];
          end else begin
            nxt_i2c   = usmc_pkg::I_WR;
            nxt_first = 1'b1;
            nxt_oe_n  = 1'b1;
          end
        end
        usmc_pkg::I_WR: begin
          if (cnt_ff == BYTE_BITS) begin
            nxt_i2c  = usmc_pkg::I_WACK;
            nxt_oe_n = 1'b0;
            if (first_ff) begin
              nxt_first    = 1'b0;
              nxt_pend     = sh_ff;
              nxt_wp       = sh_ff;
              nxt_pend_vld = 1'b1;
            end else begin
              nxt_wp = wp_ff + 8'h01;
              // byte writes at 8h to Bh.
              if (wp_ff == `USMC_ADDR_MODE) begin
                nxt_mode = sh_ff;
              end
              if (wp_ff == `USMC_ADDR_PAUSE) begin
                nxt_pause = sh_ff;
              end
              // zero edge count stored as one.
              if (wp_ff == `USMC_ADDR_EDGE) begin
                nxt_edge = (sh_ff == 8'h00) ? 8'h01 : sh_ff;
              end
              // reserved bits keep what host writes.
              if (wp_ff == `USMC_ADDR_OPT) begin
                nxt_opt = sh_ff;
              end
            end
          end
        end
        usmc_pkg::I_WACK: begin
          nxt_i2c  = usmc_pkg::I_WR;
          nxt_cnt  = 4'h0;
          nxt_oe_n = 1'b1;
        end
        usmc_pkg::I_RD: begin
          if (cnt_ff == 4'h7) begin
            nxt_i2c  = usmc_pkg::I_RACK;
            nxt_oe_n = 1'b1;
            nxt_idx  = idx_ff + 8'h01;
          end else begin
            nxt_sh   = {sh_ff[6:0], 1'b0};
            nxt_cnt  = cnt_ff + 4'h1;
            nxt_oe_n = sh_ff[6];
          end
        end
        usmc_pkg::I_RACK: begin
          if (!ack_ff) begin
            nxt_i2c  = usmc_pkg::I_RD;
            nxt_cnt  = 4'h0;
            nxt_sh   = rd_byte;
            nxt_oe_n = rd_byte[7];
          end else begin
            nxt_i2c = usmc_pkg::I_IDLE;
          end
        end
        default: nxt_i2c = usmc_pkg::I_IDLE;
      endcase
    end
    if (sw_rst) begin
      nxt_mode  = `USMC_RST_MODE;
      nxt_pause = `USMC_RST_PAUSE;
      nxt_edge  = `USMC_RST_EDGE;
      nxt_opt   = `USMC_RST_OPT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff     <= `USMC_RST_MODE;
      pause_ff    <= `USMC_RST_PAUSE;
      edge_ff     <= `USMC_RST_EDGE;
      opt_ff      <= `USMC_RST_OPT;
      idx_ff      <= `USMC_IDX_CFG;
      pend_ff     <= 8'h00;
      wp_ff       <= 8'h00;
      sh_ff       <= 8'h00;
      cnt_ff      <= 4'h0;
      rw_ff       <= 1'b0;
      first_ff    <= 1'b0;
      pend_vld_ff <= 1'b0;
      ack_ff      <= 1'b1;
      oe_n_ff     <= 1'b1;
      i2c_ff      <= usmc_pkg::I_IDLE;
    end else begin
      mode_ff     <= nxt_mode;
      pause_ff    <= nxt_pause;
      edge_ff     <= nxt_edge;
      opt_ff      <= nxt_opt;
      idx_ff      <= nxt_idx;
      pend_ff     <= nxt_pend;
      wp_ff       <= nxt_wp;
      sh_ff       <= nxt_sh;
      cnt_ff      <= nxt_cnt;
      rw_ff       <= nxt_rw;
      first_ff    <= nxt_first;
      pend_vld_ff <= nxt_pend_vld;
      ack_ff      <= nxt_ack;
      oe_n_ff     <= nxt_oe_n;
      i2c_ff      <= nxt_i2c;
    end
  end

  usmc_pkg::usmc_meas_t ms_ff, nxt_ms;
  logic [7:0] ecnt_ff, nxt_ecnt, pcnt_ff, nxt_pcnt;
  logic [1:0] tcnt_ff, nxt_tcnt;
  logic [9:0] wcnt_ff, nxt_wcnt;
  logic       awake_ff, nxt_awake, rdy_lvl_ff, nxt_rdy_lvl, rdy_oe_n_ff, nxt_rdy_oe_n;

  assign op_mode     = usmc_pkg::usmc_mode_t'(mode_ff[`USMC_MODE_MSB:`USMC_MODE_LSB]);
  assign tk.rate_sel = mode_ff[`USMC_CLK_MSB:`USMC_CLK_LSB];
  assign busy        = (ms_ff == usmc_pkg::M_MEAS);
  assign ecnt_inc    = ecnt_ff + 8'h01;
  assign go = awake_ff && (op_mode == usmc_pkg::USMC_FREE || (op_mode == usmc_pkg::USMC_CMD && cmd_start)
              || (op_mode[1] && trig_fall));

  always_comb begin
    nxt_ms     = ms_ff;
    nxt_ecnt   = ecnt_ff;
    nxt_pcnt   = pcnt_ff;
    nxt_tcnt   = tcnt_ff;
    nxt_wcnt   = wcnt_ff;
    nxt_awake  = awake_ff;
    tk.restart = 1'b0;
    meas_end   = 1'b0;
    if (mode_ff[`USMC_SB_BIT]) begin
      nxt_awake = 1'b0;
      nxt_wcnt  = 10'h000;
    end else if (!awake_ff) begin
      if (wcnt_ff == 10'(`USMC_WAKE_CYC - 1)) begin
        nxt_awake = 1'b1;
      end else begin
        nxt_wcnt = wcnt_ff + 10'h001;
      end
    end
    unique case (ms_ff)
      usmc_pkg::M_IDLE: begin
        if (go) begin
          nxt_ms   = usmc_pkg::M_MEAS;
          nxt_ecnt = 8'h00;
        end
      end
      usmc_pkg::M_MEAS: begin
        // gated end comes from the pin.
        if (op_mode == usmc_pkg::USMC_GATED) begin
          if (trig_fall) begin
            nxt_ecnt = ecnt_inc;
            meas_end = (ecnt_inc >= edge_ff);
          end
        end else begin
          meas_end = conv_done;
        end
        if (meas_end) begin
          if (op_mode == usmc_pkg::USMC_CMD) begin
            nxt_ms = usmc_pkg::M_IDLE;
          end else begin
            nxt_ms     = usmc_pkg::M_PAUSE;
            tk.restart = 1'b1;
            nxt_pcnt   = 8'h00;
            nxt_tcnt   = 2'h0;
          end
        end
      end
      usmc_pkg::M_PAUSE: begin
        if (tk.step_tick) begin
          nxt_pcnt = pcnt_ff + 8'h01;
        end
        if (tk.conv_tick && tcnt_ff != `USMC_PAUSE_MIN) begin
          nxt_tcnt = tcnt_ff + 2'h1;
        end
        // zero pause waits three conversion clocks.
        if (pause_ff == 8'h00 ? tcnt_ff == `USMC_PAUSE_MIN : pcnt_ff >= pause_ff) begin
          nxt_ms = usmc_pkg::M_IDLE;
        end
      end
      default: nxt_ms = usmc_pkg::M_IDLE;
    endcase
    if (mode_ff[`USMC_SB_BIT] || !awake_ff) begin
      nxt_ms = usmc_pkg::M_IDLE;
    end
    // open-drain pulls low only while busy.
    nxt_rdy_lvl  = mode_ff[`USMC_OD_BIT] ? 1'b0 : !busy;
    nxt_rdy_oe_n = mode_ff[`USMC_OD_BIT] ? !busy : 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ms_ff       <= usmc_pkg::M_IDLE;
      ecnt_ff     <= 8'h00;
      pcnt_ff     <= 8'h00;
      tcnt_ff     <= 2'h0;
      wcnt_ff     <= 10'h000;
      awake_ff    <= 1'b0;
      rdy_lvl_ff  <= 1'b1;
      rdy_oe_n_ff <= 1'b0;
    end else begin
      ms_ff       <= nxt_ms;
      ecnt_ff     <= nxt_ecnt;
      pcnt_ff     <= nxt_pcnt;
      tcnt_ff     <= nxt_tcnt;
      wcnt_ff     <= nxt_wcnt;
      awake_ff    <= nxt_awake;
      rdy_lvl_ff  <= nxt_rdy_lvl;
      rdy_oe_n_ff <= nxt_rdy_oe_n;
    end
  end

  assign sda_pull       = 1'b0;
  assign sda_oe_n       = oe_n_ff;
  assign ready_level    = rdy_lvl_ff;
  assign ready_oe_n     = rdy_oe_n_ff;
  assign operating_mode = mode_ff[`USMC_MODE_MSB:`USMC_MODE_LSB];
  assign standby        = mode_ff[`USMC_SB_BIT];
  assign awake          = awake_ff;
  assign clock_rate     = mode_ff[`USMC_CLK_MSB:`USMC_CLK_LSB];
  assign pause_interval = pause_ff;
  assign edge_count     = edge_ff;
  assign read_index     = idx_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_soft_reset_vals: assert property (sw_rst |=> mode_ff == `USMC_RST_MODE && pause_ff == `USMC_RST_PAUSE
    && edge_ff == `USMC_RST_EDGE && opt_ff == `USMC_RST_OPT) else $error("Soft reset left a register off reset.");
  a_edge_nonzero: assert property (edge_ff != 8'h00) else $error("Edge count register holds zero.");
  a_standby_sleep: assert property (mode_ff[`USMC_SB_BIT] |=> !awake_ff && ms_ff == usmc_pkg::M_IDLE)
    else $error("Sequencer active during standby.");
  a_wake_delay: assert property ($rose(awake_ff) |-> $past(wcnt_ff) == 10'(`USMC_WAKE_CYC - 1))
    else $error("Wake-up came early.");
  a_ready_od_low: assert property (mode_ff[`USMC_OD_BIT] && busy |=> !ready_oe_n && !ready_level)
    else $error("Open-drain ready not pulled low while busy.");
  a_ready_pp_drv: assert property (!mode_ff[`USMC_OD_BIT] |=> !ready_oe_n && ready_level == !$past(busy))
    else $error("Push-pull ready not driven from busy.");
  a_cmd_no_pause: assert property (busy && op_mode == usmc_pkg::USMC_CMD |=> ms_ff != usmc_pkg::M_PAUSE)
    else $error("Pause entered in command mode.");
  // gated end needs the edge count.
  a_gate_edges: assert property (busy && op_mode == usmc_pkg::USMC_GATED && nxt_ms == usmc_pkg::M_PAUSE
    |-> trig_fall && ecnt_inc >= edge_ff) else $error("Gated conversion ended before edge count.");
  a_pause_min: assert property (ms_ff == usmc_pkg::M_PAUSE && nxt_ms == usmc_pkg::M_IDLE && awake_ff
    && !mode_ff[`USMC_SB_BIT] && pause_ff == 8'h00 |-> tcnt_ff == `USMC_PAUSE_MIN) else $error("Zero pause too short.");
  a_stop_default: assert property (i2c_stop && opt_ff[`USMC_OPT_BIT] |=> idx_ff == $past(dflt_idx))
    else $error("Stop did not restore the default index.");
  a_stop_keep: assert property (i2c_stop && !opt_ff[`USMC_OPT_BIT] && !pend_vld_ff |=> $stable(idx_ff))
    else $error("Stop changed the index.");
  a_read_incr: assert property (i2c_ff == usmc_pkg::I_RD && scl_fall && cnt_ff == 4'h7 && !i2c_start
    && !i2c_stop |=> idx_ff == $past(idx_ff) + 8'h01) else $error("Index did not step after a read byte.");
endmodule

/* include/usmc_defines.svh */
// Offsets, field positions, reset values and timing counts of the configuration slice.
`ifndef USMC_DEFINES_SVH
`define USMC_DEFINES_SVH
`define USMC_ADDR_MODE    8'h08
`define USMC_ADDR_PAUSE   8'h09
`define USMC_ADDR_EDGE    8'h0a
`define USMC_ADDR_OPT     8'h0b
`define USMC_RST_MODE     8'h40
`define USMC_RST_PAUSE    8'h19
`define USMC_RST_EDGE     8'h01
`define USMC_RST_OPT      8'h73
`define USMC_MODE_MSB     7
`define USMC_MODE_LSB     6
`define USMC_SB_BIT       4
`define USMC_OD_BIT       3
`define USMC_CLK_MSB      1
`define USMC_CLK_LSB      0
`define USMC_OPT_BIT      0
`define USMC_IDX_MEAS     8'h02
`define USMC_IDX_CFG      8'h00
`define USMC_DEV_ADDR     7'h2a
`define USMC_CLK_NS       4
`define USMC_SYS_KHZ      (1000000 / `USMC_CLK_NS)
`define USMC_INTERNAL_CLOCK_RATE_SELECT_KHZ     1024
`define USMC_NCO_INC      ((64'd1024 << 32) / 64'd250000)
`define USMC_STEP_NS      8000
`define USMC_STEP_CYC     ((`USMC_STEP_NS + `USMC_CLK_NS - 1) / `USMC_CLK_NS)
`define USMC_WAKE_NS      4000
`define USMC_WAKE_CYC     ((`USMC_WAKE_NS + `USMC_CLK_NS - 1) / `USMC_CLK_NS)
`define USMC_PAUSE_MIN    2'h3
`endif

/* include/usmc_pkg.sv */
// Types shared by the configuration slice modules.
package usmc_pkg;
  typedef enum logic [1:0] {
    USMC_FREE  = 2'b00,
    USMC_CMD   = 2'b01,
    USMC_TRIG  = 2'b10,
    USMC_GATED = 2'b11
  } usmc_mode_t;
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_MEAS  = 2'b01,
    M_PAUSE = 2'b10
  } usmc_meas_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b010,
    I_WR   = 3'b011,
    I_WACK = 3'b100,
    I_RD   = 3'b101,
    I_RACK = 3'b110
  } usmc_i2c_t;
endpackage

/* include/usmc_tick_if.sv */
// Tick bundle between the sequencer and the conversion clock generator.
`timescale 1ns/1ps
interface usmc_tick_if;
  logic [1:0] rate_sel;
  logic       restart;
  logic       conv_tick;
  logic       step_tick;
  modport gen  (input rate_sel, input restart, output conv_tick, output step_tick);
  modport user (output rate_sel, output restart, input conv_tick, input step_tick);
endinterface

/* hdl/usmc_sync.sv */
// Two-stage pin synchroniser with edge detection.
`timescale 1ns/1ps
module usmc_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] s_ff;
  logic [2:0] nxt_s;

  always_comb begin
    nxt_s = {s_ff[1:0], pin};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= 3'h7;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign level = s_ff[1];
  assign rise  = s_ff[1] & ~s_ff[2];
  assign fall  = ~s_ff[1] & s_ff[2];
endmodule

/* hdl/usmc_tick_gen.sv */
// Conversion clock enable and pause step enable generator.
`timescale 1ns/1ps
`include "usmc_defines.svh"
module usmc_tick_gen (
  input  wire logic  clk_sys,
  input  wire logic  rst,
  usmc_tick_if.gen   tk
);
  localparam logic [31:0] INC = 32'(`USMC_NCO_INC);
  logic [31:0] acc_ff;
  logic [32:0] nxt_acc;
  logic [10:0] stp_ff;
  logic [10:0] nxt_stp;
  logic        conv_ff;
  logic        nxt_conv;
  logic        step_ff;
  logic        nxt_step;

  always_comb begin
    nxt_acc  = {1'b0, acc_ff} + {1'b0, INC << tk.rate_sel};
    nxt_conv = nxt_acc[32];
    nxt_step = (stp_ff == 11'(`USMC_STEP_CYC - 1));
    nxt_stp  = nxt_step ? 11'h000 : stp_ff + 11'h001;
    if (tk.restart) begin
      nxt_acc  = 33'h0;
      nxt_conv = 1'b0;
      nxt_step = 1'b0;
      nxt_stp  = 11'h000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_ff  <= 32'h0;
      stp_ff  <= 11'h000;
      conv_ff <= 1'b0;
      step_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc[31:0];
      stp_ff  <= nxt_stp;
      conv_ff <= nxt_conv;
      step_ff <= nxt_step;
    end
  end

  assign tk.conv_tick = conv_ff;
  assign tk.step_tick = step_ff;
endmodule

/* tb/usmc_i2c_host.sv */
// Serial bus host model that reaches the slice registers.
`timescale 1ns/1ps
module usmc_i2c_host (
  input  wire logic clk_sys,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic start();
    @(posedge clk_sys);
    sda_low <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b0;
    hp();
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
    hp();
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(ab, a);
  endtask
endmodule

/* tb/usmc_cfg_tb.sv */
// Self-checking bench of the configuration slice.
`timescale 1ns/1ps
`include "usmc_defines.svh"
module usmc_cfg_tb;
  logic       clk_sys = 1'b0, rst = 1'b1, sw_rst = 1'b0, trg = 1'b1, meas = 1'b0;
  logic       cmd_start = 1'b0, conv_done = 1'b0;
  logic       scl, sda_low, sda, sda_pull, sda_oe_n, ready_level, ready_oe_n, standby, awake, busy;
  logic [1:0] operating_mode, clock_rate;
  logic [7:0] pause_interval, edge_count, read_index;
  int         failures = 0, checked = 0, wake_n = 0;
  always #2 clk_sys = ~clk_sys;
  assign sda = ~sda_low & (sda_oe_n | sda_pull);
  always @(posedge clk_sys) wake_n <= (standby !== 1'b0) ? 0 : wake_n + 1;
  usmc_i2c_host usmc_i2c_host_i (.clk_sys(clk_sys), .scl(scl), .sda_low(sda_low), .sda(sda));
  usmc_cfg usmc_cfg_i (.clk_sys(clk_sys), .rst(rst), .sw_rst(sw_rst), .scl(scl), .sda(sda), .sda_pull(sda_pull),
    .sda_oe_n(sda_oe_n), .external_trigger_pin(trg), .cmd_start(cmd_start), .conv_done(conv_done),
    .in_measure_state(meas), .ready_level(ready_level), .ready_oe_n(ready_oe_n), .operating_mode(operating_mode),
    .standby(standby), .awake(awake), .busy(busy), .clock_rate(clock_rate), .pause_interval(pause_interval),
    .edge_count(edge_count), .read_index(read_index));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wt(input int s, input logic v, input int lim, output int n);
    logic cur;
    n = 0;
    do begin
      @(negedge clk_sys);
      cur = (s == 0) ? busy : awake;
      n++;
    end while (cur !== v && n < lim);
    chk({7'h0, cur}, {7'h0, v}, "bounded wait");
    if (cur !== v) complete_run();
  endtask
  task automatic pulse(input int s);
    @(posedge clk_sys);
    cmd_start <= (s == 0);
    conv_done <= (s == 1);
    sw_rst    <= (s == 2);
    @(posedge clk_sys);
    cmd_start <= 1'b0;
    conv_done <= 1'b0;
    sw_rst    <= 1'b0;
  endtask
  task automatic fall();
    trg <= 1'b0;
    repeat (10) @(posedge clk_sys);
    trg <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic rd(input logic rs, input logic [7:0] idx, input int n, input logic [39:0] exp);
    logic [7:0] q;
    logic       a;
    usmc_i2c_host_i.start();
    if (rs) begin
      usmc_i2c_host_i.xbyte({`USMC_DEV_ADDR, 1'b0}, 1'b1, q, a);
      usmc_i2c_host_i.xbyte(idx, 1'b1, q, a);
      usmc_i2c_host_i.start();
    end
    usmc_i2c_host_i.xbyte({`USMC_DEV_ADDR, 1'b1}, 1'b1, q, a);
    chk({7'h0, a}, 8'h00, "address ack");
    for (int i = 0; i < n; i++) begin
      usmc_i2c_host_i.xbyte(8'hff, i == n - 1, q, a);
      chk(q, exp[39 - 8 * i -: 8], "read byte");
    end
    usmc_i2c_host_i.stop();
  endtask
  task automatic wr(input logic [7:0] idx, input logic dat, input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    usmc_i2c_host_i.start();
    usmc_i2c_host_i.xbyte({`USMC_DEV_ADDR, 1'b0}, 1'b1, q, a);
    usmc_i2c_host_i.xbyte(idx, 1'b1, q, a);
    if (dat) usmc_i2c_host_i.xbyte(d, 1'b1, q, a);
    chk({7'h0, a}, 8'h00, "write ack");
    usmc_i2c_host_i.stop();
  endtask
  task automatic t_regs();
    rd(1'b1, 8'h08, 5, 40'h40_19_01_73_00);
    chk({operating_mode, standby, clock_rate, 3'h0}, 8'h40, "mode outputs");
    chk(pause_interval, 8'h19, "pause");
    chk(edge_count, 8'h01, "edges");
    $display("register reset test done");
  endtask
  task automatic t_index();
    wr(8'h0b, 1'b1, 8'h00);
    wr(8'h09, 1'b0, 8'h00);
    chk(read_index, 8'h09, "index set");
    rd(1'b0, 8'h00, 2, 40'h19_01_00_00_00);
    chk(read_index, 8'h0b, "index kept");
    wr(8'h0b, 1'b1, 8'h01);
    chk(read_index, 8'h00, "config default");
    meas <= 1'b1;
    rd(1'b0, 8'h00, 1, 40'h0);
    chk(read_index, 8'h02, "measure default");
    meas <= 1'b0;
    $display("index test done");
  endtask
  task automatic t_ready();
    int n;
    for (int od = 0; od < 2; od++) begin
      wr(8'h08, 1'b1, od ? 8'h48 : 8'h40);
      pulse(0);
      wt(0, 1'b1, 10, n);
      @(negedge clk_sys);
      chk({6'h0, ready_level, ready_oe_n}, 8'h00, "ready busy");
      pulse(1);
      wt(0, 1'b0, 10, n);
      @(negedge clk_sys);
      chk({6'h0, ready_level, ready_oe_n}, od ? 8'h01 : 8'h02, "ready idle");
    end
    $display("ready test done");
  endtask
  task automatic t_gated();
    int n;
    wr(8'h09, 1'b1, 8'h00);
    wr(8'h08, 1'b1, 8'h80);
    chk({7'h0, busy}, 8'h00, "waits for trigger");
    fall();
    wt(0, 1'b1, 10, n);
    pulse(1);
    wt(0, 1'b0, 10, n);
    wr(8'h0a, 1'b1, 8'h00);
    chk(edge_count, 8'h01, "zero edges");
    wr(8'h0a, 1'b1, 8'h02);
    wr(8'h08, 1'b1, 8'hc0);
    fall();
    wt(0, 1'b1, 10, n);
    pulse(1);
    fall();
    chk({7'h0, busy}, 8'h01, "gated running");
    fall();
    wt(0, 1'b0, 10, n);
    $display("gated test done");
  endtask
  task automatic t_wake();
    int n;
    wr(8'h08, 1'b1, 8'h50);
    chk({5'h0, standby, awake, busy}, 8'h04, "standby on");
    wr(8'h08, 1'b1, 8'h40);
    wt(1, 1'b1, 1100, n);
    chk({7'h0, wake_n inside {[995:1005]}}, 8'h01, "wake time");
    $display("wake test done");
  endtask
  task automatic t_pause();
    int n;
    wr(8'h09, 1'b1, 8'h01);
    wr(8'h08, 1'b1, 8'h03);
    chk({6'h0, clock_rate}, 8'h03, "clock rate");
    wt(0, 1'b1, 10, n);
    pulse(1);
    wt(0, 1'b0, 10, n);
    wt(0, 1'b1, 2100, n);
    chk({7'h0, n inside {[1990:2010]}}, 8'h01, "step gap");
    wr(8'h09, 1'b1, 8'h00);
    pulse(1);
    wt(0, 1'b0, 10, n);
    wt(0, 1'b1, 200, n);
    chk({7'h0, n inside {[60:100]}}, 8'h01, "minimum gap");
    $display("pause test done");
  endtask
  task automatic t_swrst();
    pulse(2);
    @(negedge clk_sys);
    chk({operating_mode, clock_rate, pause_interval[3:0]}, 8'h49, "soft reset mode");
    chk(edge_count, 8'h01, "soft reset edges");
    rd(1'b1, 8'h0b, 1, 40'h73_00_00_00_00);
    $display("soft reset test done");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_index();
    t_ready();
    t_gated();
    t_wake();
    t_pause();
    t_swrst();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    $display("CHECK FAILED %0t run too long", $time);
    complete_run();
  end
endmodule
